// ==== rtl/edhd_mode_control_registers.sv ====
// ED/HD mode control register bank with the small slice of video path
// that its settings steer: timing counters, sync outputs, DAC routing.
// Assumes one 200 MHz clock, video inputs synchronous to it, and an
// Avalon-MM master that holds each request until waitrequest is low.
//
// Implementation choice: the Avalon-MM slave port.
`default_nettype none

module edhd_mode_control_registers (
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  input  wire logic [edhd_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [edhd_pkg::DATA_W-1:0] avs_writedata_in,
  input  wire logic [edhd_pkg::BE_W-1:0]   avs_byteenable_in,
  output logic      [edhd_pkg::DATA_W-1:0] avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic [7:0]                  y_in,
  input  wire logic [7:0]                  pb_in,
  input  wire logic [7:0]                  pr_in,
  input  wire logic                        hsync_n_in,
  input  wire logic                        vsync_field_in,
  input  wire logic                        blank_in,
  output logic      [7:0]                  dac1_out,
  output logic      [7:0]                  dac2_out,
  output logic      [7:0]                  dac3_out,
  output logic                             hsync_n_out,
  output logic                             vsync_n_out,
  output logic                             blank_out,
  output logic                             rgb_input_en_out,
  output logic                             gamma_en_out,
  output logic                             gamma_curve_b_out,
  output logic                             adapt_mode_b_out,
  output logic                             adapt_en_out,
  output logic      [3:0]                  sharp_gain_a_out,
  output logic      [3:0]                  sharp_gain_b_out,
  output logic      [19:0]                 cgms_payload_out
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic addr_hit(input logic [edhd_pkg::ADDR_W-1:0] addr,
                                    input logic [7:0]                  idx);
    addr_hit = (addr[edhd_pkg::ADDR_W-1:2] == idx) &&
               (addr[1:0] == edhd_pkg::WORD_ALIGNED);
  endfunction

  logic [7:0]                  reg_q [edhd_pkg::REG_COUNT];
  logic                        waitreq_q;
  logic [edhd_pkg::DATA_W-1:0] rdata_q;
  logic [edhd_pkg::DATA_W-1:0] rdata_d;
  logic                        wr_go;
  logic [edhd_pkg::H_W-1:0]    h_cnt_q;
  logic [edhd_pkg::V_W-1:0]    v_cnt_q;

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait state: waitrequest drops for exactly one cycle per access,
  // which also gives read data a full cycle to settle in its flop.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !((avs_read_in || avs_write_in) && waitreq_q);
    end
  end

  assign wr_go = avs_write_in && !waitreq_q && avs_byteenable_in[0];

  // ****************************************
  // Register storage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < edhd_pkg::REG_COUNT; g++) begin : g_reg
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          reg_q[g] <= edhd_pkg::REG_RESET[g];
        end else if (wr_go && addr_hit(avs_address_in, edhd_pkg::REG_INDEX[g])) begin
          reg_q[g] <= avs_writedata_in[7:0] & edhd_pkg::REG_WMASK[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < edhd_pkg::REG_COUNT; i++) begin
      if (addr_hit(avs_address_in, edhd_pkg::REG_INDEX[i])) begin
        rdata_d = edhd_pkg::DATA_W'(reg_q[i]);
      end
    end
    if (addr_hit(avs_address_in, edhd_pkg::IDX_POSITION)) begin
      rdata_d = edhd_pkg::DATA_W'({v_cnt_q, h_cnt_q});
    end
  end

  // Captured on the edge that drops waitrequest; unmapped reads give zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else if (avs_read_in && waitreq_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = waitreq_q;

  // ****************************************
  // Decoded settings
  // ****************************************
  logic sync_sel;
  logic pattern_en;
  logic timing_rst;
  logic hs_ctl;
  logic vs_ctl;
  logic blank_pol;
  logic vsync_mode;
  logic free_run;
  logic sync_prpb;
  logic dac_swap;

  assign sync_sel   = reg_q[edhd_pkg::SLOT_SYS][edhd_pkg::BIT_SYNC_SEL];
  assign pattern_en = reg_q[edhd_pkg::SLOT_PAT][edhd_pkg::BIT_PATTERN_EN];
  assign timing_rst = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_TIMING_RST];
  assign hs_ctl     = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_HSYNC_CTL];
  assign vs_ctl     = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_VSYNC_CTL];
  assign blank_pol  = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_BLANK_POL];
  assign vsync_mode = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_VSYNC_IN];
  assign free_run   = reg_q[edhd_pkg::SLOT_TIM][edhd_pkg::BIT_FREE_RUN];
  assign sync_prpb  = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_SYNC_PRPB];
  assign dac_swap   = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_DAC_SWAP];

  // Settings handed straight to the filter and gamma stages
  assign rgb_input_en_out  = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_RGB_EN];
  assign gamma_en_out      = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_GAMMA_EN];
  assign gamma_curve_b_out = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_GAMMA_SEL];
  assign adapt_mode_b_out  = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_ADAPT_MODE];
  assign adapt_en_out      = reg_q[edhd_pkg::SLOT_IO][edhd_pkg::BIT_ADAPT_EN];
  // Two's complement, passed raw: the filter sign-extends
  assign sharp_gain_a_out  = reg_q[edhd_pkg::SLOT_SHP][3:0];
  assign sharp_gain_b_out  = reg_q[edhd_pkg::SLOT_SHP][7:4];
  assign cgms_payload_out  = {reg_q[edhd_pkg::SLOT_CGH][3:0],
                              reg_q[edhd_pkg::SLOT_CGM],
                              reg_q[edhd_pkg::SLOT_CGL]};

  // ****************************************
  // Timing counters
  // ****************************************
  logic hs_prev_q;
  logic vs_prev_q;
  logic hs_fall;
  logic v_start;
  logic h_wrap;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_prev_q <= 1'b1;
      vs_prev_q <= 1'b1;
    end else begin
      hs_prev_q <= hsync_n_in;
      vs_prev_q <= vsync_field_in;
    end
  end

  assign hs_fall = hs_prev_q && !hsync_n_in;
  // Field input marks a new field on either edge, vsync only on its fall
  assign v_start = vsync_mode ? (vs_prev_q && !vsync_field_in)
                              : (vs_prev_q != vsync_field_in);
  assign h_wrap  = free_run ? hs_fall
                            : (h_cnt_q == edhd_pkg::H_LAST);

  always_ff @(posedge clk_in) begin
    if (srst_in || timing_rst) begin
      h_cnt_q <= '0;
    end else if (h_wrap) begin
      h_cnt_q <= '0;
    end else begin
      h_cnt_q <= h_cnt_q + 1'b1;
    end
  end

  // Free running: rolls over at full width if external sync never comes
  always_ff @(posedge clk_in) begin
    if (srst_in || timing_rst) begin
      v_cnt_q <= '0;
    end else if (free_run) begin
      if (v_start) begin
        v_cnt_q <= '0;
      end else if (h_wrap) begin
        v_cnt_q <= v_cnt_q + 1'b1;
      end
    end else if (h_wrap) begin
      if (v_cnt_q == edhd_pkg::V_LAST) begin
        v_cnt_q <= '0;
      end else begin
        v_cnt_q <= v_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Sync and blank outputs
  // ****************************************
  logic hs_act;
  logic vs_act;
  logic blank_act;

  assign hs_act    = h_cnt_q < edhd_pkg::H_SYNC_LEN;
  assign vs_act    = v_cnt_q < edhd_pkg::V_SYNC_LEN;
  assign blank_act = blank_in ^ blank_pol;

  logic hsync_n_q;
  logic vsync_n_q;
  logic blank_q;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hsync_n_q <= 1'b1;
      vsync_n_q <= 1'b1;
      blank_q   <= 1'b0;
    end else begin
      hsync_n_q <= !(hs_act && (!sync_sel || hs_ctl));
      vsync_n_q <= !(vs_act && (!sync_sel || vs_ctl));
      blank_q   <= blank_act;
    end
  end

  assign hsync_n_out = hsync_n_q;
  assign vsync_n_out = vsync_n_q;
  assign blank_out   = blank_q;

  // ****************************************
  // DAC routing
  // ****************************************
  logic [7:0] y_src;
  logic [7:0] pb_src;
  logic [7:0] pr_src;
  logic [7:0] dac1_q;
  logic [7:0] dac2_q;
  logic [7:0] dac3_q;

  assign y_src  = pattern_en ? reg_q[edhd_pkg::SLOT_LUM] : y_in;
  assign pb_src = pattern_en ? reg_q[edhd_pkg::SLOT_CB] : pb_in;
  assign pr_src = pattern_en ? reg_q[edhd_pkg::SLOT_CR] : pr_in;

  // Sync insertion wins over blanking so the tip survives blank intervals
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dac1_q <= edhd_pkg::BLACK_Y;
      dac2_q <= edhd_pkg::BLACK_C;
      dac3_q <= edhd_pkg::BLACK_C;
    end else if (sync_prpb && hs_act) begin
      dac1_q <= edhd_pkg::BLACK_Y;
      dac2_q <= edhd_pkg::SYNC_LEVEL;
      dac3_q <= edhd_pkg::SYNC_LEVEL;
    end else if (blank_act) begin
      dac1_q <= edhd_pkg::BLACK_Y;
      dac2_q <= edhd_pkg::BLACK_C;
      dac3_q <= edhd_pkg::BLACK_C;
    end else begin
      dac1_q <= y_src;
      dac2_q <= dac_swap ? pr_src : pb_src;
      dac3_q <= dac_swap ? pb_src : pr_src;
    end
  end

  assign dac1_out = dac1_q;
  assign dac2_out = dac2_q;
  assign dac3_out = dac3_q;

endmodule

`default_nettype wire

// ==== rtl/edhd_pkg.sv ====
// Constants for the ED/HD mode control register bank: register indexes,
// reset values, write masks, bit positions and video timing figures.
// Assumes a 32-bit Avalon-MM slave whose byte address is four times the index.
`default_nettype none

package edhd_pkg;

  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;
  localparam int BE_W      = 4;
  localparam int REG_COUNT = 12;

  // ****************************************
  // Register indexes (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] IDX_SYS_SYNC    = 8'h02;
  localparam logic [7:0] IDX_PATTERN     = 8'h31;
  localparam logic [7:0] IDX_TIMING      = 8'h34;
  localparam logic [7:0] IDX_IO_OPT      = 8'h35;
  localparam logic [7:0] IDX_LUMA        = 8'h36;
  localparam logic [7:0] IDX_RED_DIFF    = 8'h37;
  localparam logic [7:0] IDX_BLUE_DIFF   = 8'h38;
  localparam logic [7:0] IDX_COMPLY      = 8'h39;
  localparam logic [7:0] IDX_SHARP       = 8'h40;
  localparam logic [7:0] IDX_CGMS_HIGH   = 8'h41;
  localparam logic [7:0] IDX_CGMS_MID    = 8'h42;
  localparam logic [7:0] IDX_CGMS_LOW    = 8'h43;
  localparam logic [7:0] IDX_POSITION    = 8'h60;
  localparam logic [1:0] WORD_ALIGNED    = 2'h0;

  // Storage slots, in the order of the tables below
  localparam int SLOT_SYS = 0;
  localparam int SLOT_PAT = 1;
  localparam int SLOT_TIM = 2;
  localparam int SLOT_IO  = 3;
  localparam int SLOT_LUM = 4;
  localparam int SLOT_CR  = 5;
  localparam int SLOT_CB  = 6;
  localparam int SLOT_SHP = 8;
  localparam int SLOT_CGH = 9;
  localparam int SLOT_CGM = 10;
  localparam int SLOT_CGL = 11;

  localparam logic [7:0] REG_INDEX [REG_COUNT] = '{
    IDX_SYS_SYNC, IDX_PATTERN, IDX_TIMING, IDX_IO_OPT, IDX_LUMA, IDX_RED_DIFF,
    IDX_BLUE_DIFF, IDX_COMPLY, IDX_SHARP, IDX_CGMS_HIGH, IDX_CGMS_MID, IDX_CGMS_LOW};
  localparam logic [7:0] REG_RESET [REG_COUNT] = '{
    8'h00, 8'h00, 8'h48, 8'h00, 8'hA0, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Reserved bits are never stored, so they read back as zero
  localparam logic [7:0] REG_WMASK [REG_COUNT] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'h20, 8'hFF, 8'h0F, 8'hFF, 8'hFF};

  // ****************************************
  // Bit positions
  // ****************************************
  localparam int BIT_SYNC_SEL    = 7;
  localparam int BIT_PATTERN_EN  = 2;
  localparam int BIT_TIMING_RST  = 0;
  localparam int BIT_HSYNC_CTL   = 1;
  localparam int BIT_VSYNC_CTL   = 2;
  localparam int BIT_BLANK_POL   = 3;
  localparam int BIT_VSYNC_IN    = 6;
  localparam int BIT_FREE_RUN    = 7;
  localparam int BIT_RGB_EN      = 1;
  localparam int BIT_SYNC_PRPB   = 2;
  localparam int BIT_DAC_SWAP    = 3;
  localparam int BIT_GAMMA_SEL   = 4;
  localparam int BIT_GAMMA_EN    = 5;
  localparam int BIT_ADAPT_MODE  = 6;
  localparam int BIT_ADAPT_EN    = 7;

  // ****************************************
  // Timing and levels
  // ****************************************
  localparam int H_W = 11;
  localparam int V_W = 10;
  localparam logic [H_W-1:0] H_LAST     = 11'h671;
  localparam logic [V_W-1:0] V_LAST     = 10'h2ED;
  localparam logic [H_W-1:0] H_SYNC_LEN = 11'h028;
  localparam logic [V_W-1:0] V_SYNC_LEN = 10'h005;
  localparam logic [7:0]     BLACK_Y    = 8'h10;
  localparam logic [7:0]     BLACK_C    = 8'h80;
  localparam logic [7:0]     SYNC_LEVEL = 8'h00;

endpackage

`default_nettype wire

// ==== sim/edhd_mode_control_registers_checker.sv ====
// Assertions on the register bank's bus handshake and setting outputs.
// Assumes binding to the bank; sees only its ports.
`default_nettype none

module edhd_mode_control_registers_checker (
  input wire logic                        clk_in,
  input wire logic                        srst_in,
  input wire logic [edhd_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic                        avs_read_in,
  input wire logic                        avs_write_in,
  input wire logic [edhd_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [edhd_pkg::BE_W-1:0]   avs_byteenable_in,
  input wire logic                        avs_waitrequest_out,
  input wire logic                        rgb_input_en_out,
  input wire logic                        gamma_en_out,
  input wire logic                        gamma_curve_b_out,
  input wire logic                        adapt_mode_b_out,
  input wire logic                        adapt_en_out,
  input wire logic [3:0]                  sharp_gain_a_out,
  input wire logic [3:0]                  sharp_gain_b_out,
  input wire logic [19:0]                 cgms_payload_out
);
  // ****************************************
  // Handshake and write effects
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_wr(logic [7:0] idx);
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
    avs_address_in == {idx, 2'h0};
  endsequence

  property p_one_wait; s_req |=> !avs_waitrequest_out; endproperty
  property p_ack_pulse; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  property p_no_spurious;
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in);
  endproperty
  property p_io_bits;
    s_wr(8'h35) |=> {adapt_en_out, adapt_mode_b_out, gamma_en_out, gamma_curve_b_out,
      rgb_input_en_out} == {$past(avs_writedata_in[7:4]), $past(avs_writedata_in[1])};
  endproperty
  property p_sharp;
    s_wr(8'h40) |=> {sharp_gain_b_out, sharp_gain_a_out} == $past(avs_writedata_in[7:0]);
  endproperty
  property p_cg_high;
    s_wr(8'h41) |=> cgms_payload_out[19:16] == $past(avs_writedata_in[3:0]);
  endproperty
  property p_cg_mid;
    s_wr(8'h42) |=> cgms_payload_out[15:8] == $past(avs_writedata_in[7:0]);
  endproperty
  property p_cg_low;
    s_wr(8'h43) |=> cgms_payload_out[7:0] == $past(avs_writedata_in[7:0]);
  endproperty
  // Gains, payload and RGB input enable move only on a completed, enabled write
  property p_hold;
    !(avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) |=>
      $stable({sharp_gain_b_out, sharp_gain_a_out, cgms_payload_out, rgb_input_en_out});
  endproperty

  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_no_spurious: assert property (p_no_spurious) else $error("ack without request");
  a_io_bits: assert property (p_io_bits) else $error("option bits wrong");
  a_sharp: assert property (p_sharp) else $error("gains wrong");
  a_cg_high: assert property (p_cg_high) else $error("payload high wrong");
  a_cg_mid: assert property (p_cg_mid) else $error("payload mid wrong");
  a_cg_low: assert property (p_cg_low) else $error("payload low wrong");
  a_hold: assert property (p_hold) else $error("setting moved without write");
endmodule

bind edhd_mode_control_registers edhd_mode_control_registers_checker u_chk (
  .clk_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_byteenable_in, .avs_waitrequest_out, .rgb_input_en_out, .gamma_en_out,
  .gamma_curve_b_out, .adapt_mode_b_out, .adapt_en_out, .sharp_gain_a_out,
  .sharp_gain_b_out, .cgms_payload_out);

`default_nettype wire

// ==== sim/edhd_mode_control_registers_tb.sv ====
// Self-checking bench for the register bank and the video slice it steers.
// Assumes one wait cycle per bus access; the bench drives all ports itself.
`default_nettype none

module edhd_mode_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clk_in = 1'b0;
  logic                        srst_in = 1'b1;
  logic [edhd_pkg::ADDR_W-1:0] avs_address_in = '0;
  logic                        avs_read_in = 1'b0;
  logic                        avs_write_in = 1'b0;
  logic [edhd_pkg::DATA_W-1:0] avs_writedata_in = '0;
  logic [edhd_pkg::BE_W-1:0]   avs_byteenable_in = 4'hF;
  logic [edhd_pkg::DATA_W-1:0] avs_readdata_out;
  logic                        avs_waitrequest_out;
  logic [7:0]                  y_in = 8'h55, pb_in = 8'h33, pr_in = 8'h44;
  logic                        hsync_n_in = 1'b1, vsync_field_in = 1'b1, blank_in = 1'b1;
  logic [7:0]                  dac1_out, dac2_out, dac3_out;
  logic                        hsync_n_out, vsync_n_out, blank_out, rgb_input_en_out;
  logic                        gamma_en_out, gamma_curve_b_out, adapt_mode_b_out, adapt_en_out;
  logic [3:0]                  sharp_gain_a_out, sharp_gain_b_out;
  logic [19:0]                 cgms_payload_out;
  int                          n_fail = 0, total_checks = 0;
  localparam logic [7:0] IDX [10] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h40,
                                      8'h41, 8'h42, 8'h43};
  localparam logic [7:0] RST [10] = '{8'h48, 8'h00, 8'hA0, 8'h80, 8'h80, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RBK [10] = '{8'hBF, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'h20, 8'hFF,
                                      8'h0F, 8'hFF, 8'hFF};

  always #2.5 clk_in = ~clk_in;

  edhd_mode_control_registers uut (
    .clk_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .y_in, .pb_in, .pr_in,
    .hsync_n_in, .vsync_field_in, .blank_in, .dac1_out, .dac2_out, .dac3_out,
    .hsync_n_out, .vsync_n_out, .blank_out, .rgb_input_en_out, .gamma_en_out,
    .gamma_curve_b_out, .adapt_mode_b_out, .adapt_en_out, .sharp_gain_a_out,
    .sharp_gain_b_out, .cgms_payload_out);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ack();
    int n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 40);
    if (n >= 40) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    avs_address_in <= {idx, 2'h0};
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= 1'b1;
    ack();
    avs_write_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d);
    @(posedge clk_in);
    avs_address_in <= {idx, 2'h0};
    avs_read_in <= 1'b1;
    ack();
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    rd_reg(idx, d);
    chk(d, {24'h0, e});
  endtask
  // Sync, blank and DAC outputs are registered after the register update
  task automatic settle();
    repeat (3) @(posedge clk_in);
  endtask
  // Cycles up to the next falling edge of the sync output
  task automatic fall(output int n);
    logic p;
    n = 0;
    do begin
      p = hsync_n_out;
      @(posedge clk_in);
      n++;
    end while (!(p === 1'b1 && hsync_n_out === 1'b0) && n < 4000);
    if (n >= 4000) begin
      n_fail++;
      end_sim();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int i = 0; i < 10; i++) rd_chk(IDX[i], RST[i]);
    rd_chk(8'h50, 8'h00);
    chk({sharp_gain_b_out, sharp_gain_a_out, cgms_payload_out}, 28'h0);
    $display("reset values done");
  endtask
  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 10; i++) wr_reg(IDX[i], IDX[i] == 8'h34 ? 8'hBF : 8'hFF);
    for (int i = 0; i < 10; i++) rd_chk(IDX[i], RBK[i]);
    chk(cgms_payload_out, 20'hFFFFF);
    avs_byteenable_in <= 4'hE;
    wr_reg(8'h42, 8'h00);
    avs_byteenable_in <= 4'hF;
    rd_chk(8'h42, 8'hFF);
    wr_reg(8'h50, 8'hFF);
    rd_chk(8'h50, 8'h00);
    wr_reg(8'h40, 8'h8F);
    settle();
    chk({sharp_gain_b_out, sharp_gain_a_out}, 8'h8F);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hB2 : 8'h40;
      wr_reg(8'h35, v);
      settle();
      chk({adapt_en_out, adapt_mode_b_out, gamma_en_out, gamma_curve_b_out,
           rgb_input_en_out}, {v[7:4], v[1]});
    end
    $display("register access done");
  endtask
  task automatic t_video();
    logic [31:0] d;
    wr_reg(8'h34, 8'h09);
    rd_reg(8'h60, d);
    chk(d, 32'h0);
    chk({hsync_n_out, vsync_n_out}, 2'b00);
    wr_reg(8'h02, 8'h80);
    settle();
    chk({hsync_n_out, vsync_n_out}, 2'b11);
    wr_reg(8'h34, 8'h0F);
    settle();
    chk({hsync_n_out, vsync_n_out}, 2'b00);
    wr_reg(8'h35, 8'h04);
    settle();
    chk({dac2_out, dac3_out}, 16'h0000);
    wr_reg(8'h35, 8'h00);
    settle();
    chk({dac1_out, dac2_out, dac3_out}, 24'h553344);
    wr_reg(8'h35, 8'h08);
    settle();
    chk({dac2_out, dac3_out}, 16'h4433);
    wr_reg(8'h36, 8'h12);
    wr_reg(8'h38, 8'h21);
    wr_reg(8'h31, 8'h04);
    settle();
    chk({dac1_out, dac2_out, dac3_out}, 24'h12FF21);
    blank_in <= 1'b0;
    settle();
    chk({blank_out, dac1_out}, 9'h110);
    wr_reg(8'h34, 8'h01);
    settle();
    chk(blank_out, 1'b0);
    blank_in <= 1'b1;
    $display("video path done");
  endtask
  task automatic t_wrap();
    logic [31:0] d;
    int          n;
    wr_reg(8'h02, 8'h00);
    wr_reg(8'h34, 8'h08);
    fall(n);
    fall(n);
    chk(n, 32'd1650);
    wr_reg(8'h34, 8'h89);
    wr_reg(8'h34, 8'h88);
    repeat (1700) @(posedge clk_in);
    rd_reg(8'h60, d);
    chk(32'(d[10:0] > 11'h671), 32'h1);
    hsync_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    hsync_n_in <= 1'b1;
    rd_reg(8'h60, d);
    chk(32'(d[10:0] < 11'h010), 32'h1);
    chk(32'(d[20:11]), 32'h1);
    vsync_field_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd_reg(8'h60, d);
    chk(32'(d[20:11]), 32'h0);
    wr_reg(8'h34, 8'hC8);
    vsync_field_in <= 1'b1;
    hsync_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    hsync_n_in <= 1'b1;
    rd_reg(8'h60, d);
    chk(32'(d[20:11]), 32'h1);
    vsync_field_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd_reg(8'h60, d);
    chk(32'(d[20:11]), 32'h0);
    $display("counter wrap done");
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_regs();
    t_video();
    t_wrap();
    end_sim();
  end
endmodule

`default_nettype wire
